// ===== rtl/gpio_port_pkg.sv
// How it works
// - Eight two-way pins, each with direction bit, output latch bit and input read.
// - Direction bit 1 turns the pin's output driver off, making it an input.
// - Direction bit 0 turns the driver on and drives the latch value.
// - Port reads return sampled pin levels; port writes update the latch only.
// - Port set and clear writes are read-modify-write: pin levels read, modified, stored to latch.
// - Direction bits still control the driver while the pin serves analog input.
// - A pin selected as analog input reads 0 through the digital read path.
// - Open-drain bit set: pin only sinks current, never drives high.
// - Open-drain bit clear: pin is a push-pull driver, sourcing and sinking.
// - Slew-limit bit set rate-limits edges; clear switches at full speed.
// - Threshold bit selects Schmitt CMOS or TTL levels for each pin's input.
// - The chosen threshold sets both port reads and pin-change detection level.
// - With several sources enabled, the highest fixed-priority source drives the pin.
// - Analog and most digital inputs stay outside priority and always see the pin.
// - Designated digital input functions override other functions and join the priority.
// - Pins 0,2 latch only; pin 1 op-amp 3 first; pin 3 controller 4 A first.
// - Pins 4,5 controller 3 F,E; pin 6 D, comparator 3; pin 7 C, comparator 4.
package gpio_port_pkg;
   localparam int unsigned PORT_WIDTH = 8;
   localparam int unsigned ADDR_WIDTH = 4;

   // Register byte offsets
   localparam logic [3:0] OFF_PORT      = 4'h0;
   localparam logic [3:0] OFF_LATCH     = 4'h1;
   localparam logic [3:0] OFF_DIR       = 4'h2;
   localparam logic [3:0] OFF_OPEN      = 4'h3;
   localparam logic [3:0] OFF_SLEW      = 4'h4;
   localparam logic [3:0] OFF_THRESH    = 4'h5;
   localparam logic [3:0] OFF_ANALOG    = 4'h6;
   localparam logic [3:0] OFF_PORT_SET  = 4'h7;
   localparam logic [3:0] OFF_PORT_CLR  = 4'h8;

   // Reset values
   localparam logic [7:0] RST_LATCH  = 8'h00;
   localparam logic [7:0] RST_DIR    = 8'hff;
   localparam logic [7:0] RST_OPEN   = 8'h00;
   localparam logic [7:0] RST_SLEW   = 8'hff;
   localparam logic [7:0] RST_THRESH = 8'h00;
   localparam logic [7:0] RST_ANALOG = 8'h00;
   localparam logic [7:0] RST_RDATA  = 8'h00;

   // Pin positions with peripheral sources
   localparam int unsigned PIN_OPAMP3 = 1;
   localparam int unsigned PIN_SMC4A  = 3;
   localparam int unsigned PIN_SMC3F  = 4;
   localparam int unsigned PIN_SMC3E  = 5;
   localparam int unsigned PIN_SMC3D  = 6;
   localparam int unsigned PIN_SMC3C  = 7;
endpackage : gpio_port_pkg

// ===== rtl/gpio_port.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_port
   import gpio_port_pkg::*;
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_resetn,
   // Register port
   input  wire logic [ADDR_WIDTH-1:0] i_addr,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [7:0]            o_rdata,
   // Pad side
   input  wire logic [7:0]            i_pin_schmitt,
   input  wire logic [7:0]            i_pin_ttl,
   output logic      [7:0]            o_pin_out,
   output logic      [7:0]            o_pin_oe,
   output logic      [7:0]            o_slew_limit,
   output logic      [7:0]            o_ttl_select,
   output logic      [7:0]            o_analog_select,
   // Peripheral sources and their output enables
   input  wire logic                  i_opamp_three_output,
   input  wire logic                  i_opamp_three_en,
   input  wire logic                  i_switch_mode_ctl4_out_a,
   input  wire logic                  i_switch_mode_ctl4_en_a,
   input  wire logic                  i_switch_mode_ctl3_out_f,
   input  wire logic                  i_switch_mode_ctl3_en_f,
   input  wire logic                  i_switch_mode_ctl3_out_e,
   input  wire logic                  i_switch_mode_ctl3_en_e,
   input  wire logic                  i_switch_mode_ctl3_out_d,
   input  wire logic                  i_switch_mode_ctl3_en_d,
   input  wire logic                  i_switch_mode_ctl3_out_c,
   input  wire logic                  i_switch_mode_ctl3_en_c,
   input  wire logic                  i_comparator_three_output,
   input  wire logic                  i_comparator_three_en,
   input  wire logic                  i_comparator_four_output,
   input  wire logic                  i_comparator_four_en,
   // Designated input functions that claim their pin
   input  wire logic [7:0]            i_input_override,
   // Threshold-resolved pin level for peripherals and pin-change logic
   output logic      [7:0]            o_pin_level
);

   logic [7:0] port_output_latch;
   logic [7:0] port_direction_bits;
   logic [7:0] open_drain_select_bits;
   logic [7:0] slew_limit_select_bits;
   logic [7:0] input_threshold_select_bits;
   logic [7:0] analog_select_bits;
   logic [7:0] next_port_output_latch;
   logic [7:0] next_port_direction_bits;
   logic [7:0] next_open_drain_select_bits;
   logic [7:0] next_slew_limit_select_bits;
   logic [7:0] next_input_threshold_select_bits;
   logic [7:0] next_analog_select_bits;
   logic [7:0] fourth_port_pin_value;
   logic [7:0] next_fourth_port_pin_value;
   logic [7:0] next_rdata;
   logic [7:0] digital_read;
   logic [7:0] drive_value;
   logic [7:0] drive_enable;

   // Control registers
   always_comb begin
      next_port_output_latch           = port_output_latch;
      next_port_direction_bits         = port_direction_bits;
      next_open_drain_select_bits      = open_drain_select_bits;
      next_slew_limit_select_bits      = slew_limit_select_bits;
      next_input_threshold_select_bits = input_threshold_select_bits;
      next_analog_select_bits          = analog_select_bits;
      if (i_wr) begin
         case (i_addr)
            OFF_PORT,
            OFF_LATCH:    next_port_output_latch = i_wdata;
            // Bit operations start from the sampled pins, not the latch, and store to the latch
            OFF_PORT_SET: next_port_output_latch = digital_read | i_wdata;
            OFF_PORT_CLR: next_port_output_latch = digital_read & ~i_wdata;
            OFF_DIR:      next_port_direction_bits = i_wdata;
            OFF_OPEN:     next_open_drain_select_bits = i_wdata;
            OFF_SLEW:     next_slew_limit_select_bits = i_wdata;
            OFF_THRESH:   next_input_threshold_select_bits = i_wdata;
            OFF_ANALOG:   next_analog_select_bits = i_wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         port_output_latch           <= RST_LATCH;
         port_direction_bits         <= RST_DIR;
         open_drain_select_bits      <= RST_OPEN;
         slew_limit_select_bits      <= RST_SLEW;
         input_threshold_select_bits <= RST_THRESH;
         analog_select_bits          <= RST_ANALOG;
      end else begin
         port_output_latch           <= next_port_output_latch;
         port_direction_bits         <= next_port_direction_bits;
         open_drain_select_bits      <= next_open_drain_select_bits;
         slew_limit_select_bits      <= next_slew_limit_select_bits;
         input_threshold_select_bits <= next_input_threshold_select_bits;
         analog_select_bits          <= next_analog_select_bits;
      end
   end

   // Pin sampling through the selected threshold
   always_comb begin
      next_fourth_port_pin_value = (i_pin_ttl & input_threshold_select_bits)
                                 | (i_pin_schmitt & ~input_threshold_select_bits);
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fourth_port_pin_value <= RST_RDATA;
      end else begin
         fourth_port_pin_value <= next_fourth_port_pin_value;
      end
   end

   // Analog pins still feed peripherals, but the port read masks them
   assign digital_read = fourth_port_pin_value & ~analog_select_bits;
   assign o_pin_level  = fourth_port_pin_value;

   // Read data
   always_comb begin
      next_rdata = RST_RDATA;
      if (i_rd) begin
         case (i_addr)
            OFF_PORT:   next_rdata = digital_read;
            OFF_LATCH:  next_rdata = port_output_latch;
            OFF_DIR:    next_rdata = port_direction_bits;
            OFF_OPEN:   next_rdata = open_drain_select_bits;
            OFF_SLEW:   next_rdata = slew_limit_select_bits;
            OFF_THRESH: next_rdata = input_threshold_select_bits;
            OFF_ANALOG: next_rdata = analog_select_bits;
            default:    next_rdata = RST_RDATA;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= RST_RDATA;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // Fixed-priority source selection, highest first
   always_comb begin
      drive_value  = port_output_latch;
      drive_enable = 8'hff;
      if (i_opamp_three_en) begin
         drive_value[PIN_OPAMP3] = i_opamp_three_output;
      end
      if (i_switch_mode_ctl4_en_a) begin
         drive_value[PIN_SMC4A] = i_switch_mode_ctl4_out_a;
      end
      if (i_switch_mode_ctl3_en_f) begin
         drive_value[PIN_SMC3F] = i_switch_mode_ctl3_out_f;
      end
      if (i_switch_mode_ctl3_en_e) begin
         drive_value[PIN_SMC3E] = i_switch_mode_ctl3_out_e;
      end
      if (i_switch_mode_ctl3_en_d) begin
         drive_value[PIN_SMC3D] = i_switch_mode_ctl3_out_d;
      end else if (i_comparator_three_en) begin
         drive_value[PIN_SMC3D] = i_comparator_three_output;
      end
      if (i_switch_mode_ctl3_en_c) begin
         drive_value[PIN_SMC3C] = i_switch_mode_ctl3_out_c;
      end else if (i_comparator_four_en) begin
         drive_value[PIN_SMC3C] = i_comparator_four_output;
      end
      // An overriding input function outranks every output source
      drive_enable = ~i_input_override;
   end

   // Per-pin driver
   genvar g;
   generate
      for (g = 0; g < PORT_WIDTH; g++) begin : g_pin
         always_comb begin
            // Direction rules even when analog is selected
            if (port_direction_bits[g] || !drive_enable[g]) begin
               o_pin_oe[g]  = 1'b0;
               o_pin_out[g] = 1'b0;
            end else if (open_drain_select_bits[g]) begin
               o_pin_oe[g]  = ~drive_value[g];
               o_pin_out[g] = 1'b0;
            end else begin
               o_pin_oe[g]  = 1'b1;
               o_pin_out[g] = drive_value[g];
            end
         end
      end
   endgenerate

   assign o_slew_limit    = slew_limit_select_bits;
   assign o_ttl_select    = input_threshold_select_bits;
   assign o_analog_select = analog_select_bits;

   // Checks
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_port_read;
      i_rd && i_addr == OFF_PORT;
   endsequence

   sequence s_set_write;
      i_wr && i_addr == OFF_PORT_SET;
   endsequence

   AST_INPUT_HIZ: assert property ((o_pin_oe & port_direction_bits) == 8'h00)
      else $error("Input pin has its driver on");

   AST_LATCH_DRIVE: assert property (!port_direction_bits[0] && !open_drain_select_bits[0]
      && !i_input_override[0] |-> o_pin_oe[0] && o_pin_out[0] == port_output_latch[0])
      else $error("Output pin does not drive latch");

   AST_OPEN_DRAIN: assert property ((o_pin_oe & o_pin_out & open_drain_select_bits) == 8'h00)
      else $error("Open-drain pin driven high");

   AST_PORT_WRITE: assert property (i_wr && i_addr == OFF_PORT |=> port_output_latch == $past(i_wdata))
      else $error("Port write did not reach latch");

   AST_RMW_SET: assert property (s_set_write |=> port_output_latch == $past(digital_read | i_wdata))
      else $error("Set write not based on pin levels");

   AST_ANALOG_ZERO: assert property (s_port_read |=> (o_rdata & $past(analog_select_bits)) == 8'h00)
      else $error("Analog pin read as one");

   AST_PORT_READ: assert property (s_port_read |=> o_rdata == $past(fourth_port_pin_value & ~analog_select_bits))
      else $error("Port read value wrong");

   AST_OPAMP_PRIO: assert property (i_opamp_three_en && !port_direction_bits[1]
      && !open_drain_select_bits[1] && !i_input_override[1] |-> o_pin_out[1] == i_opamp_three_output)
      else $error("Op-amp does not own pin one");

   AST_PIN6_PRIO: assert property (!i_switch_mode_ctl3_en_d && i_comparator_three_en && !port_direction_bits[6]
      && !open_drain_select_bits[6] && !i_input_override[6] |-> o_pin_out[6] == i_comparator_three_output)
      else $error("Comparator three not second on pin six");

   AST_THRESHOLD: assert property (##1 o_pin_level == $past(input_threshold_select_bits & i_pin_ttl
      | ~input_threshold_select_bits & i_pin_schmitt))
      else $error("Pin level ignores threshold");

   AST_OVERRIDE: assert property ((o_pin_oe & i_input_override) == 8'h00)
      else $error("Overridden pin still driven");

   AST_PUSH_PULL: assert property ((~port_direction_bits & ~open_drain_select_bits & ~i_input_override
      & (~o_pin_oe | (o_pin_out ^ drive_value))) == 8'h00)
      else $error("Push-pull pin not driving its value");

   AST_LATCH_ONLY: assert property ((o_pin_oe & ~open_drain_select_bits & (o_pin_out ^ port_output_latch)
      & 8'h05) == 8'h00)
      else $error("Pin zero or two not driven from latch");

   AST_ANALOG_DRIVE: assert property ((analog_select_bits & ~port_direction_bits & ~open_drain_select_bits
      & ~i_input_override & ~o_pin_oe) == 8'h00)
      else $error("Analog output pin lost its driver");

   AST_PIN3_PRIO: assert property (i_switch_mode_ctl4_en_a && !port_direction_bits[3]
      && !open_drain_select_bits[3] && !i_input_override[3] |-> o_pin_out[3] == i_switch_mode_ctl4_out_a)
      else $error("Controller four A does not own pin three");

   AST_PIN4_PRIO: assert property (i_switch_mode_ctl3_en_f && !port_direction_bits[4]
      && !open_drain_select_bits[4] && !i_input_override[4] |-> o_pin_out[4] == i_switch_mode_ctl3_out_f)
      else $error("Controller three F does not own pin four");

   AST_PIN5_PRIO: assert property (i_switch_mode_ctl3_en_e && !port_direction_bits[5]
      && !open_drain_select_bits[5] && !i_input_override[5] |-> o_pin_out[5] == i_switch_mode_ctl3_out_e)
      else $error("Controller three E does not own pin five");

   AST_PIN6_FIRST: assert property (i_switch_mode_ctl3_en_d && !port_direction_bits[6]
      && !open_drain_select_bits[6] && !i_input_override[6] |-> o_pin_out[6] == i_switch_mode_ctl3_out_d)
      else $error("Controller three D not first on pin six");

   AST_PIN7_PRIO: assert property (!i_switch_mode_ctl3_en_c && i_comparator_four_en
      && !port_direction_bits[7] && !open_drain_select_bits[7] && !i_input_override[7]
      |-> o_pin_out[7] == i_comparator_four_output)
      else $error("Comparator four not second on pin seven");

   AST_CTRL_HOLD: assert property (!i_wr |=> $stable(port_output_latch) && $stable(port_direction_bits)
      && $stable(open_drain_select_bits) && $stable(slew_limit_select_bits)
      && $stable(input_threshold_select_bits))
      else $error("Control bits changed without a write");

   // Idle bus shows zero so stale data never looks fresh
   AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == RST_RDATA)
      else $error("Read data stood without a read");

   sequence s_clr_write;
      i_wr && i_addr == OFF_PORT_CLR;
   endsequence

   AST_RMW_CLR: assert property (s_clr_write |=> port_output_latch == $past(digital_read & ~i_wdata))
      else $error("Clear write not based on pin levels");

   sequence s_slew_write;
      i_wr && i_addr == OFF_SLEW;
   endsequence

   AST_SLEW: assert property (s_slew_write |=> o_slew_limit == $past(i_wdata))
      else $error("Slew limit not taken from write");

   sequence s_thresh_write;
      i_wr && i_addr == OFF_THRESH;
   endsequence

   AST_TTL_SELECT: assert property (s_thresh_write |=> o_ttl_select == $past(i_wdata))
      else $error("Threshold select not taken from write");

endmodule // gpio_port

`default_nettype wire

// ===== tb/pad_board.sv
`timescale 1ns/1ps
`default_nettype none

module pad_board (
   input  wire logic [7:0] i_pin_out,
   input  wire logic [7:0] i_pin_oe,
   input  wire logic [7:0] i_ext_level,
   input  wire logic [7:0] i_mid_band,
   output logic      [7:0] o_schmitt,
   output logic      [7:0] o_ttl
);
   logic [7:0] wire_level;

   // Released pins fall to the board level, a pull resistor in practice
   assign wire_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
   // Mid-band voltage sits under the Schmitt high level but over the TTL one
   assign o_schmitt = wire_level & ~i_mid_band;
   assign o_ttl     = wire_level | i_mid_band;
endmodule // pad_board

`default_nettype wire

// ===== tb/tb_eight_bit_gpio_port_with_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

module tb_eight_bit_gpio_port_with_pin_mux;
   import gpio_port_pkg::*;
   localparam logic [7:0] RST_TAB [1:6] = '{RST_LATCH, RST_DIR, RST_OPEN, RST_SLEW, RST_THRESH, RST_ANALOG};
   localparam logic [7:0] PR_TAB [4][3] = '{'{8'hff, 8'hff, 8'hfa}, '{8'hc0, 8'hff, 8'h00},
                                           '{8'hc0, 8'hc0, 8'hc0}, '{8'h00, 8'hff, 8'h05}};
   logic                  i_sys_clk = 1'b0;
   logic                  i_resetn  = 1'b0;
   logic                  i_wr      = 1'b0;
   logic                  i_rd      = 1'b0;
   logic [ADDR_WIDTH-1:0] i_addr    = '0;
   logic [7:0]            i_wdata   = 8'h00;
   logic [7:0]            ext       = 8'h00;
   logic [7:0]            mid       = 8'h00;
   logic [7:0]            pv        = 8'h00;
   logic [7:0]            pe        = 8'h00;
   logic [7:0]            ovr       = 8'h00;
   logic [7:0]            o_rdata, o_pin_out, o_pin_oe, o_slew_limit, o_ttl_select, o_analog_select, o_pin_level;
   logic [7:0]            sch, ttl;
   int                    err_count = 0;
   int                    tests_run = 0;

   gpio_port u_gpio_port (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_schmitt(sch), .i_pin_ttl(ttl),
      .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_slew_limit(o_slew_limit), .o_ttl_select(o_ttl_select),
      .o_analog_select(o_analog_select), .i_opamp_three_output(pv[0]), .i_opamp_three_en(pe[0]),
      .i_switch_mode_ctl4_out_a(pv[1]), .i_switch_mode_ctl4_en_a(pe[1]), .i_switch_mode_ctl3_out_f(pv[2]),
      .i_switch_mode_ctl3_en_f(pe[2]), .i_switch_mode_ctl3_out_e(pv[3]), .i_switch_mode_ctl3_en_e(pe[3]),
      .i_switch_mode_ctl3_out_d(pv[4]), .i_switch_mode_ctl3_en_d(pe[4]), .i_switch_mode_ctl3_out_c(pv[5]),
      .i_switch_mode_ctl3_en_c(pe[5]), .i_comparator_three_output(pv[6]), .i_comparator_three_en(pe[6]),
      .i_comparator_four_output(pv[7]), .i_comparator_four_en(pe[7]), .i_input_override(ovr),
      .o_pin_level(o_pin_level));

   pad_board u_pad_board (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext_level(ext), .i_mid_band(mid),
      .o_schmitt(sch), .o_ttl(ttl));

   initial begin
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      chk(what, o_rdata, exp);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(25 * 3000);
      err_count++;
      test_done;
   end

   initial begin
      repeat (6) @(posedge i_sys_clk);
      chk("oe_rst", o_pin_oe, 8'h00);
      i_resetn <= 1'b1;
      for (int i = 1; i <= 6; i++) rdc("rst", 4'(i), RST_TAB[i]);
      $display("test reset done");
      wr(OFF_DIR, 8'h00);
      wr(OFF_LATCH, 8'ha5);
      @(negedge i_sys_clk);
      chk("oe", o_pin_oe, 8'hff);
      chk("out", o_pin_out, 8'ha5);
      rdc("port", OFF_PORT, 8'ha5);
      wr(OFF_PORT, 8'h3c);
      rdc("latch", OFF_LATCH, 8'h3c);
      $display("test drive done");
      wr(OFF_DIR, 8'hff);
      ext <= 8'hf0;
      wr(OFF_PORT_SET, 8'h0f);
      rdc("set", OFF_LATCH, 8'hff);
      wr(OFF_PORT_CLR, 8'h30);
      rdc("clr", OFF_LATCH, 8'hc0);
      $display("test rmw done");
      wr(OFF_ANALOG, 8'h0f);
      ext <= 8'hff;
      rdc("analog", OFF_PORT, 8'hf0);
      chk("level", o_pin_level, 8'hff);
      chk("asel", o_analog_select, 8'h0f);
      wr(OFF_DIR, 8'h00);
      @(negedge i_sys_clk);
      chk("oe_an", o_pin_oe, 8'hff);
      wr(OFF_ANALOG, 8'h00);
      wr(OFF_OPEN, 8'hff);
      wr(OFF_LATCH, 8'h0f);
      @(negedge i_sys_clk);
      chk("od_out", o_pin_out, 8'h00);
      chk("od_oe", o_pin_oe, 8'hf0);
      rdc("od_port", OFF_PORT, 8'h0f);
      wr(OFF_OPEN, 8'h00);
      @(negedge i_sys_clk);
      chk("pp", o_pin_oe & o_pin_out, 8'h0f);
      wr(OFF_SLEW, 8'h5a);
      @(negedge i_sys_clk);
      chk("slew", o_slew_limit, 8'h5a);
      $display("test driver done");
      // Peripherals all idle while thresholds change
      wr(OFF_DIR, 8'hff);
      ext <= 8'h00;
      mid <= 8'hff;
      rdc("cmos", OFF_PORT, 8'h00);
      chk("lvl_cmos", o_pin_level, 8'h00);
      wr(OFF_THRESH, 8'hff);
      rdc("ttl", OFF_PORT, 8'hff);
      chk("lvl_ttl", o_pin_level, 8'hff);
      chk("tsel", o_ttl_select, 8'hff);
      wr(OFF_THRESH, 8'h00);
      mid <= 8'h00;
      $display("test threshold done");
      wr(OFF_DIR, 8'h00);
      wr(OFF_LATCH, 8'h00);
      for (int k = 0; k < 4; k++) begin
         if (k == 3)
            wr(OFF_LATCH, 8'hff);
         @(posedge i_sys_clk);
         pv <= PR_TAB[k][0];
         pe <= PR_TAB[k][1];
         @(negedge i_sys_clk);
         chk("prio", o_pin_out, PR_TAB[k][2]);
      end
      @(posedge i_sys_clk);
      ovr <= 8'h80;
      @(negedge i_sys_clk);
      chk("ovr", o_pin_oe, 8'h7f);
      wr(4'h9, 8'h55);
      rdc("unmapped", 4'h9, 8'h00);
      rdc("kept", OFF_LATCH, 8'hff);
      $display("test mux done");
      test_done;
   end
endmodule // tb_eight_bit_gpio_port_with_pin_mux

`default_nettype wire
